// ===== logic/fic_regs.svh
// Offsets, field positions, reset values for the frame index counter
`ifndef FIC_REGS_SVH
`define FIC_REGS_SVH
`define FIC_ADDR_W 8
`define FIC_FRAME_INDEX_OFS 8'h3C
`define FIC_FRAME_INDEX_W 14
`define FIC_FRAME_INDEX_RST 14'h0000
`define FIC_FRAME_INDEX_MAX 14'h3FFF
`define FIC_FRAME_INDEX_ONE 14'h0001
`define FIC_RDATA_RST 32'h0000_0000
`define FIC_SF_BIT 2
`define FIC_IRQ_NONE 32'h0000_0000
`endif

// ===== logic/fic_pkg.sv
// Types for the frame index counter
package fic_pkg;
   typedef enum logic [3:0] {
      FIC_IDLE = 4'b0001,
      FIC_WAIT_SOF = 4'b0010,
      FIC_WRITE = 4'b0100,
      FIC_FETCH_OK = 4'b1000
   } fic_seq_e;

   typedef struct packed {
      fic_seq_e st;
      logic sf;
   } fic_seq_s;

   typedef struct packed {
      logic [13:0] idx;
      logic [31:0] rdata;
   } fic_top_s;
endpackage : fic_pkg

// ===== logic/fic_area_writer.sv
// Frame-boundary sequencer: shared area write, then start-of-frame flag and descriptor fetch release
`timescale 1ns/1ps
module fic_area_writer (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic frame_tick,
   input wire logic sof_sent,
   input wire logic mem_ack,
   output logic mem_req,
   output logic sf_pulse,
   output logic fetch_ok
);
   fic_pkg::fic_seq_s s_r;
   fic_pkg::fic_seq_s s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.sf = 1'b0;
      unique case (s_r.st)
         fic_pkg::FIC_IDLE, fic_pkg::FIC_FETCH_OK: begin
            if (frame_tick) begin
               s_nxt.st = fic_pkg::FIC_WAIT_SOF;
            end
         end
         fic_pkg::FIC_WAIT_SOF: begin
            if (sof_sent) begin
               s_nxt.st = fic_pkg::FIC_WRITE;
            end
         end
         fic_pkg::FIC_WRITE: begin
            if (mem_ack) begin
               s_nxt.st = fic_pkg::FIC_FETCH_OK;
               s_nxt.sf = 1'b1;
            end
         end
         default: begin
            s_nxt.st = fic_pkg::FIC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_r <= '{st: fic_pkg::FIC_IDLE, sf: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign mem_req = (s_r.st == fic_pkg::FIC_WRITE);
   assign sf_pulse = s_r.sf;
   assign fetch_ok = (s_r.st == fic_pkg::FIC_FETCH_OK);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_write_after_sof;
      $rose(mem_req) |-> $past(sof_sent);
   endproperty
   a_write_after_sof: assert property (p_write_after_sof)
      else $error("Shared area write began without a sent token");

   property p_fetch_after_write;
      $rose(fetch_ok) |-> $past(mem_req && mem_ack);
   endproperty
   a_fetch_after_write: assert property (p_fetch_after_write)
      else $error("Descriptor fetch released before shared area write");

   property p_sf_after_write;
      (mem_req && mem_ack) |=> sf_pulse ##1 !sf_pulse;
   endproperty
   a_sf_after_write: assert property (p_sf_after_write)
      else $error("Frame start flag not pulsed once after write");

   property p_sf_cause;
      sf_pulse |-> $past(mem_req && mem_ack) && fetch_ok;
   endproperty
   a_sf_cause: assert property (p_sf_cause)
      else $error("Frame start flag without completed write");
endmodule : fic_area_writer

// ===== logic/fic_frame_index.sv
// Frame index counter with register port and shared area publishing
//
// Behaviour
// - Index advances by one on every frame-time-left reload.
// - Index wraps to zero after its largest value.
// - Index advances once on entry to the operational state.
// - Index is written to the shared area after increment and start token.
// - Shared area write finishes before the first endpoint descriptor fetch.
// - Frame start flag, status bit 2, is set after that write.
// - Register readable and writable at offset 3Ch in function 0 or 1.
`timescale 1ns/1ps
`include "fic_regs.svh"
module fic_frame_index (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic FRAME_RELOAD,
   input wire logic ENTER_OPERATIONAL,
   input wire logic SOF_SENT,
   input wire logic REG_SEL,
   input wire logic [`FIC_ADDR_W-1:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [31:0] REG_WDATA,
   output logic [31:0] REG_RDATA,
   output logic MEM_WR_REQ,
   output logic [15:0] MEM_WR_DATA,
   input wire logic MEM_WR_ACK,
   output logic [31:0] IRQ_STATUS_SET,
   output logic ED_FETCH_OK
);
   fic_pkg::fic_top_s s_r;
   fic_pkg::fic_top_s s_nxt;
   logic hit;
   logic sf_pulse;

   function automatic logic [13:0] fic_inc(input logic [13:0] v);
      fic_inc = (v == `FIC_FRAME_INDEX_MAX) ? `FIC_FRAME_INDEX_RST : 14'(v + `FIC_FRAME_INDEX_ONE);
   endfunction : fic_inc

   // Decode offset in either function window
   assign hit = REG_SEL && (REG_ADDR == `FIC_FRAME_INDEX_OFS);

   always_comb begin
      s_nxt = s_r;
      if (hit && REG_WR) begin
         s_nxt.idx = REG_WDATA[`FIC_FRAME_INDEX_W-1:0];
      end
      // Reload increments; hardware wins over write
      if (FRAME_RELOAD || ENTER_OPERATIONAL) begin
         s_nxt.idx = fic_inc(s_r.idx);
      end
      if (hit && REG_RD) begin
         s_nxt.rdata = {18'h0_0000, s_r.idx};
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         s_r <= '{idx: `FIC_FRAME_INDEX_RST, rdata: `FIC_RDATA_RST};
      end else begin
         s_r <= s_nxt;
      end
   end

   fic_area_writer u_writer (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .frame_tick(FRAME_RELOAD),
      .sof_sent(SOF_SENT),
      .mem_ack(MEM_WR_ACK),
      .mem_req(MEM_WR_REQ),
      .sf_pulse(sf_pulse),
      .fetch_ok(ED_FETCH_OK)
   );

   assign REG_RDATA = s_r.rdata;
   // Shared area slot is 16 bits wide; top two bits stay zero
   assign MEM_WR_DATA = {2'b00, s_r.idx};

   always_comb begin
      IRQ_STATUS_SET = `FIC_IRQ_NONE;
      IRQ_STATUS_SET[`FIC_SF_BIT] = sf_pulse;
   end

   property p_reload_inc;
      @(posedge SYS_CLK) disable iff (!RST_N)
      FRAME_RELOAD |=> s_r.idx == fic_inc($past(s_r.idx));
   endproperty
   a_reload_inc: assert property (p_reload_inc)
      else $error("Frame index did not advance on reload");

   property p_wrap;
      @(posedge SYS_CLK) disable iff (!RST_N)
      (FRAME_RELOAD && s_r.idx == 14'h3FFF) |=> s_r.idx == 14'h0000;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("Frame index did not wrap to zero");

   property p_oper_inc;
      @(posedge SYS_CLK) disable iff (!RST_N)
      (ENTER_OPERATIONAL && !FRAME_RELOAD) |=> s_r.idx == 14'($past(s_r.idx) + 14'h0001);
   endproperty
   a_oper_inc: assert property (p_oper_inc)
      else $error("Frame index did not advance on operational entry");

   property p_read;
      @(posedge SYS_CLK) disable iff (!RST_N)
      (REG_SEL && REG_RD && REG_ADDR == 8'h3C) |=> REG_RDATA == {18'h0_0000, $past(s_r.idx)};
   endproperty
   a_read: assert property (p_read)
      else $error("Register read returned wrong value");

   property p_reset;
      @(posedge SYS_CLK)
      !RST_N |=> s_r.idx == 14'h0000 && REG_RDATA == 32'h0000_0000;
   endproperty
   a_reset: assert property (p_reset)
      else $error("Register not cleared by reset");

   property p_write_lands;
      @(posedge SYS_CLK) disable iff (!RST_N)
      (hit && REG_WR && !FRAME_RELOAD && !ENTER_OPERATIONAL) |=>
         {18'h0_0000, s_r.idx} == ($past(REG_WDATA) & 32'h0000_3FFF);
   endproperty
   a_write_lands: assert property (p_write_lands)
      else $error("Register write did not land in the index");

   property p_unmapped_wr;
      @(posedge SYS_CLK) disable iff (!RST_N)
      (REG_SEL && REG_WR && REG_ADDR != `FIC_FRAME_INDEX_OFS && !FRAME_RELOAD && !ENTER_OPERATIONAL) |=>
         $stable(s_r.idx);
   endproperty
   a_unmapped_wr: assert property (p_unmapped_wr)
      else $error("Write to another offset changed the index");

   property p_idx_hold;
      @(posedge SYS_CLK) disable iff (!RST_N)
      (!FRAME_RELOAD && !ENTER_OPERATIONAL && !(hit && REG_WR)) |=> $stable(s_r.idx);
   endproperty
   a_idx_hold: assert property (p_idx_hold)
      else $error("Frame index changed without a cause");

   property p_both_once;
      @(posedge SYS_CLK) disable iff (!RST_N)
      (FRAME_RELOAD && ENTER_OPERATIONAL) |=> s_r.idx == 14'($past(s_r.idx) + 14'h0001);
   endproperty
   a_both_once: assert property (p_both_once)
      else $error("Reload with operational entry did not advance by one");

   property p_rdata_hold;
      @(posedge SYS_CLK) disable iff (!RST_N)
      !(hit && REG_RD) |=> $stable(REG_RDATA);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("Read data changed without a read");

   property p_rdata_top;
      @(posedge SYS_CLK) disable iff (!RST_N)
      REG_RDATA[31:`FIC_FRAME_INDEX_W] == 18'h0_0000;
   endproperty
   a_rdata_top: assert property (p_rdata_top)
      else $error("Reserved read bits not zero");

   property p_req_stands;
      @(posedge SYS_CLK) disable iff (!RST_N)
      (MEM_WR_REQ && !MEM_WR_ACK) |=> MEM_WR_REQ;
   endproperty
   a_req_stands: assert property (p_req_stands)
      else $error("Shared area request dropped before acknowledge");

   property p_req_ends;
      @(posedge SYS_CLK) disable iff (!RST_N)
      (MEM_WR_REQ && MEM_WR_ACK) |=> !MEM_WR_REQ;
   endproperty
   a_req_ends: assert property (p_req_ends)
      else $error("Shared area request stayed after acknowledge");

   property p_irq_only_sf;
      @(posedge SYS_CLK) disable iff (!RST_N)
      (IRQ_STATUS_SET & 32'hFFFF_FFFB) == `FIC_IRQ_NONE;
   endproperty
   a_irq_only_sf: assert property (p_irq_only_sf)
      else $error("Status set pulse on a bit other than frame start");

   property p_sf_once;
      @(posedge SYS_CLK) disable iff (!RST_N)
      IRQ_STATUS_SET[`FIC_SF_BIT] |=> !IRQ_STATUS_SET[`FIC_SF_BIT];
   endproperty
   a_sf_once: assert property (p_sf_once)
      else $error("Frame start set pulse longer than one cycle");

   property p_sf_with_fetch;
      @(posedge SYS_CLK) disable iff (!RST_N)
      IRQ_STATUS_SET[`FIC_SF_BIT] |-> ED_FETCH_OK && !MEM_WR_REQ;
   endproperty
   a_sf_with_fetch: assert property (p_sf_with_fetch)
      else $error("Frame start flag while shared area write pending");

   property p_fetch_drop;
      @(posedge SYS_CLK) disable iff (!RST_N)
      (FRAME_RELOAD && !MEM_WR_REQ) |=> !ED_FETCH_OK;
   endproperty
   a_fetch_drop: assert property (p_fetch_drop)
      else $error("Descriptor fetch still allowed after frame boundary");

   property p_fetch_wait;
      @(posedge SYS_CLK) disable iff (!RST_N)
      (!ED_FETCH_OK && !(MEM_WR_REQ && MEM_WR_ACK)) |=> !ED_FETCH_OK;
   endproperty
   a_fetch_wait: assert property (p_fetch_wait)
      else $error("Descriptor fetch allowed without a finished write");

   property p_fetch_stays;
      @(posedge SYS_CLK) disable iff (!RST_N)
      (ED_FETCH_OK && !FRAME_RELOAD) |=> ED_FETCH_OK;
   endproperty
   a_fetch_stays: assert property (p_fetch_stays)
      else $error("Descriptor fetch permission lost inside the frame");

   property p_reset_outputs;
      @(posedge SYS_CLK)
      !RST_N |=> !MEM_WR_REQ && !ED_FETCH_OK && IRQ_STATUS_SET == `FIC_IRQ_NONE && MEM_WR_DATA == 16'h0000;
   endproperty
   a_reset_outputs: assert property (p_reset_outputs)
      else $error("Outputs not cleared by reset");
endmodule : fic_frame_index

// ===== test/fic_mem_model.sv
// Shared-area memory model that acknowledges index writes after a delay
`timescale 1ns/1ps
module fic_mem_model #(
   parameter int DLY = 3
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic req,
   input wire logic [15:0] data,
   output logic ack,
   output logic [15:0] cap
);
   int cnt;
   // Slow answer so the descriptor fetch hold-off can be seen
   always_ff @(posedge clk) begin
      ack <= 1'b0;
      if (!rst_n) begin
         cnt <= 0;
         cap <= 16'h0000;
      end else if (req && !ack) begin
         cnt <= (cnt == DLY) ? 0 : cnt + 1;
         ack <= (cnt == DLY);
         if (cnt == DLY) cap <= data;
      end
   end
endmodule : fic_mem_model

// ===== test/test_fic_frame_index.sv
// Register and frame-sequence tests of the frame index counter
`timescale 1ns/1ps
`include "fic_regs.svh"
module test_fic_frame_index;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic rel = 1'b0, opn = 1'b0, sof = 1'b0, sel = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] rdata, irq;
   logic mreq, mack, fok;
   logic [15:0] mdata, mcap;
   int fails = 0, n_checks = 0, cyc = 0;
   always #2.5 clk = ~clk;
   fic_frame_index fic_frame_index_i (.SYS_CLK(clk), .RST_N(rst_n), .FRAME_RELOAD(rel),
      .ENTER_OPERATIONAL(opn), .SOF_SENT(sof), .REG_SEL(sel), .REG_ADDR(addr), .REG_WR(wr),
      .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata), .MEM_WR_REQ(mreq), .MEM_WR_DATA(mdata),
      .MEM_WR_ACK(mack), .IRQ_STATUS_SET(irq), .ED_FETCH_OK(fok));
   fic_mem_model fic_mem_model_i (.clk(clk), .rst_n(rst_n), .req(mreq), .data(mdata), .ack(mack),
      .cap(mcap));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // Idle cycle after each strobe keeps one assignment per time step
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(posedge clk);
      #1 s = 1'b0;
      @(posedge clk);
      #1;
   endtask : pulse
   // Select drops with the strobe, so back-to-back calls never touch it twice in one step
   task automatic acc(input logic [7:0] a, input logic [31:0] d, input logic w);
      addr = a;
      wdata = d;
      sel = 1'b1;
      wr = w;
      rd = !w;
      @(posedge clk);
      #1 sel = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      @(posedge clk);
      #1;
   endtask : acc
   task automatic frame(input logic [15:0] exp);
      pulse(rel);
      chk("fetch_hold", 32'(fok), 32'h0000_0000);
      pulse(sof);
      chk("area_req", 32'(mreq), 32'h0000_0001);
      chk("fetch_wait", 32'(fok), 32'h0000_0000);
      for (int i = 0; i < 20 && irq[`FIC_SF_BIT] !== 1'b1; i++) @(posedge clk) #1;
      chk("sf_set", irq, 32'h0000_0004);
      chk("fetch_ok", 32'(fok), 32'h0000_0001);
      chk("area_data", {16'h0000, mcap}, {16'h0000, exp});
      chk("area_done", 32'(mreq), 32'h0000_0000);
      @(posedge clk) #1;
      chk("sf_end", irq, 32'h0000_0000);
      chk("fetch_stays", 32'(fok), 32'h0000_0001);
      acc(8'h3C, 32'h0000_0000, 1'b0);
      chk("index", rdata, {16'h0000, exp});
   endtask : frame
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : end_sim
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         fails++;
         end_sim();
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      #1 rst_n = 1'b1;
      acc(8'h3C, 32'h0000_0000, 1'b0);
      chk("reset", rdata, 32'h0000_0000);
      acc(8'h3C, 32'h0000_3FFE, 1'b1);
      acc(8'h3C, 32'h0000_0000, 1'b0);
      chk("rw", rdata, 32'h0000_3FFE);
      acc(8'h40, 32'h0000_0123, 1'b1);
      acc(8'h40, 32'h0000_0000, 1'b0);
      chk("unmapped_rd", rdata, 32'h0000_3FFE);
      frame(16'h3FFF);
      frame(16'h0000);
      pulse(opn);
      chk("oper_no_write", 32'(mreq), 32'h0000_0000);
      acc(8'h3C, 32'h0000_0000, 1'b0);
      chk("operational", rdata, 32'h0000_0001);
      addr = 8'h3C;
      wdata = 32'h0000_0100;
      sel = 1'b1;
      wr = 1'b1;
      rel = 1'b1;
      @(posedge clk);
      #1 sel = 1'b0;
      wr = 1'b0;
      rel = 1'b0;
      @(posedge clk);
      #1;
      acc(8'h3C, 32'h0000_0000, 1'b0);
      chk("hw_wins", rdata, 32'h0000_0002);
      opn = 1'b1;
      rel = 1'b1;
      @(posedge clk);
      #1 opn = 1'b0;
      rel = 1'b0;
      @(posedge clk);
      #1;
      acc(8'h3C, 32'h0000_0000, 1'b0);
      chk("both_once", rdata, 32'h0000_0003);
      frame(16'h0004);
      rst_n = 1'b0;
      @(posedge clk);
      #1 rst_n = 1'b1;
      chk("reset_fetch", 32'(fok), 32'h0000_0000);
      chk("reset_irq", irq, 32'h0000_0000);
      acc(8'h3C, 32'h0000_0000, 1'b0);
      chk("reset_again", rdata, 32'h0000_0000);
      end_sim();
   end
endmodule : test_fic_frame_index
